// ==== core/acds_top.v ====
// Behaviour
// - Bit 6 of the live status reads 1 while the master clock is halted, 0 while it runs.
// - Bit 5 reads 1 while the PLL is unlocked or disabled, 0 while it is enabled and locked.
// - Bit 4 reads 1 only while frame and bit clocks both sit low, 0 if either runs.
// - Bit 3 reads 1 when rate and master clock ratio cannot be auto set up, else 0.
// - Bit 2 reads 1 unless the master clock ratio to the frame rate is detectable.
// - Bit 2 also reads 1 when the frame clock low phase spans five bit clocks or fewer.
// - Bit 1 reads 1 unless bit clocks per frame are stable and within 32 to 256.
// - Bit 0 reads 1 when the sampling rate cannot be detected and ignore-all-errors is clear.
// - Bit 0 is forced to 0 while the ignore-all-errors setting lets the converter recover.
// - A master clock halt is latched in bit 4 of the second register, cleared by reading it.
// - Any clock error is latched in bit 0 of the second register until read, then cleared.
// - Second register bit 1 shows resync in progress, bit 2 shows both serial clocks missing.
`timescale 1ns/1ps
`include "acds_defs.vh"
module acds_top #(
  parameter MCLK_HALT_CYC = `ACDS_MCLK_HALT_CYC,
  parameter MISS_CYC = `ACDS_MISS_CYC,
  parameter RESYNC_CYC = `ACDS_RESYNC_CYC
) (
  input wire ref_clk,
  input wire rst,
  input wire mclk,
  input wire sclk,
  input wire lrclk,
  input wire pll_enable,
  input wire pll_locked,
  input wire ignore_all_errors,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rdata_valid
);

  // Master clock ratios the detector recognises
  function ratio_ok;
    input [11:0] r;
    begin
      case (r)
        12'h020, 12'h030, 12'h040, 12'h080, 12'h0c0, 12'h100,
        12'h180, 12'h200, 12'h300, 12'h400, 12'h480, 12'h600,
        12'h800, 12'hc00: ratio_ok = 1'b1;
        default: ratio_ok = 1'b0;
      endcase
    end
  endfunction

  // Two-stage synchronisers, one per pin
  wire [3:0] pin_raw = {pll_locked, lrclk, sclk, mclk};
  wire [3:0] sync2;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      always @(posedge ref_clk) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
        end
      end
      assign sync2[gi] = s2;
    end
  endgenerate

  // Edge stage for the three clock pins
  reg [2:0] sync3;
  always @(posedge ref_clk) begin
    if (rst)
      sync3 <= 3'h0;
    else
      sync3 <= sync2[2:0];
  end

  wire mclk_rise = sync2[0] & ~sync3[0];
  wire sclk_rise = sync2[1] & ~sync3[1];
  wire lr_rise = sync2[2] & ~sync3[2];
  wire lr_level = sync2[2];
  wire pll_lock_s = sync2[3];

  // Master clock halt watchdog
  reg [15:0] halt_cnt;
  reg mclk_halted;
  always @(posedge ref_clk) begin
    if (rst) begin
      halt_cnt <= 16'h0000;
      mclk_halted <= 1'b1;
    end else if (mclk_rise) begin
      halt_cnt <= 16'h0000;
      mclk_halted <= 1'b0;
    end else if (halt_cnt >= MCLK_HALT_CYC[15:0] - 16'h0001) begin
      mclk_halted <= 1'b1;
    end else begin
      halt_cnt <= halt_cnt + 16'h0001;
    end
  end

  // Both serial clocks held low
  reg [15:0] miss_cnt;
  reg ser_missing;
  always @(posedge ref_clk) begin
    if (rst) begin
      miss_cnt <= 16'h0000;
      ser_missing <= 1'b1;
    end else if (sync2[1] | sync2[2]) begin
      miss_cnt <= 16'h0000;
      ser_missing <= 1'b0;
    end else if (miss_cnt >= MISS_CYC[15:0] - 16'h0001) begin
      ser_missing <= 1'b1;
    end else begin
      miss_cnt <= miss_cnt + 16'h0001;
    end
  end

  // Per-frame counters, closed on each frame clock rise
  reg [8:0] sclk_cnt;
  reg [8:0] sclk_ratio;
  reg sclk_stable;
  reg [3:0] low_cnt;
  reg low_short;
  reg [11:0] mclk_cnt;
  reg [11:0] mclk_ratio;
  reg mclk_stable;
  reg [11:0] frame_cyc;
  reg [11:0] frame_len;
  reg frame_seen;
  wire frame_timeout = frame_cyc > `ACDS_FRAME_MAX_CYC;

  // Bit clocks per frame and low phase length
  always @(posedge ref_clk) begin
    if (rst) begin
      sclk_cnt <= 9'h000;
      sclk_ratio <= 9'h000;
      sclk_stable <= 1'b0;
      low_cnt <= 4'h0;
      low_short <= 1'b0;
    end else if (lr_rise) begin
      sclk_cnt <= {8'h00, sclk_rise};
      sclk_ratio <= sclk_cnt;
      sclk_stable <= frame_seen && (sclk_cnt == sclk_ratio);
      low_cnt <= 4'h0;
      low_short <= low_cnt <= `ACDS_LOW_LIMIT;
    end else begin
      if (sclk_rise && sclk_cnt != 9'h1ff)
        sclk_cnt <= sclk_cnt + 9'h001;
      if (sclk_rise && !lr_level && low_cnt != 4'hf)
        low_cnt <= low_cnt + 4'h1;
      if (frame_timeout)
        sclk_stable <= 1'b0;
    end
  end

  // Master clocks per frame
  always @(posedge ref_clk) begin
    if (rst) begin
      mclk_cnt <= 12'h000;
      mclk_ratio <= 12'h000;
      mclk_stable <= 1'b0;
    end else if (lr_rise) begin
      mclk_cnt <= {11'h000, mclk_rise};
      mclk_ratio <= mclk_cnt;
      mclk_stable <= frame_seen && (mclk_cnt == mclk_ratio);
    end else begin
      if (mclk_rise && mclk_cnt != 12'hfff)
        mclk_cnt <= mclk_cnt + 12'h001;
      if (frame_timeout)
        mclk_stable <= 1'b0;
    end
  end

  // Frame period in reference clock cycles
  always @(posedge ref_clk) begin
    if (rst) begin
      frame_cyc <= 12'h000;
      frame_len <= 12'h000;
      frame_seen <= 1'b0;
    end else if (lr_rise) begin
      frame_cyc <= 12'h001;
      frame_len <= frame_cyc;
      frame_seen <= ~frame_timeout;
    end else begin
      if (frame_cyc != 12'hfff)
        frame_cyc <= frame_cyc + 12'h001;
      if (frame_timeout)
        frame_seen <= 1'b0;
    end
  end

  // Detector results
  wire rate_ok = frame_seen && !frame_timeout && frame_len >= `ACDS_FRAME_MIN_CYC &&
    frame_len <= `ACDS_FRAME_MAX_CYC;
  wire sclk_ok = sclk_stable && sclk_ratio >= `ACDS_SCLK_MIN &&
    sclk_ratio <= `ACDS_SCLK_MAX;
  wire mclk_ok = rate_ok && mclk_stable && !mclk_halted && ratio_ok(mclk_ratio) &&
    !low_short;
  wire combo_bad = !mclk_ok || (mclk_ratio >= `ACDS_AUTO_MAX_RATIO &&
    frame_len < `ACDS_FAST_CYC);

  // Live flags, recomputed every cycle
  reg [6:0] flags;
  reg [6:0] next_flags;
  always @* begin
    next_flags = 7'h00;
    next_flags[`ACDS_B_MCLK_HALT] = mclk_halted;
    next_flags[`ACDS_B_PLL_UNLK] = ~pll_enable | ~pll_lock_s;
    next_flags[`ACDS_B_SER_MISS] = ser_missing;
    next_flags[`ACDS_B_COMBO] = combo_bad;
    next_flags[`ACDS_B_MCLK_INV] = ~mclk_ok;
    next_flags[`ACDS_B_SCLK_INV] = ~sclk_ok;
    next_flags[`ACDS_B_FS_INV] = ~rate_ok & ~ignore_all_errors;
  end

  always @(posedge ref_clk) begin
    if (rst)
      flags <= `ACDS_FLAGS_RST;
    else
      flags <= next_flags;
  end

  // Resync window after errors clear
  wire err_now = |flags;
  reg err_prev;
  reg [15:0] resync_cnt;
  wire resync_in_progress = resync_cnt != 16'h0000;
  always @(posedge ref_clk) begin
    if (rst)
      err_prev <= 1'b0;
    else
      err_prev <= err_now;
  end

  always @(posedge ref_clk) begin
    if (rst)
      resync_cnt <= 16'h0000;
    else if (err_prev && !err_now)
      resync_cnt <= RESYNC_CYC[15:0];
    else if (err_now)
      resync_cnt <= 16'h0000;
    else if (resync_in_progress)
      resync_cnt <= resync_cnt - 16'h0001;
  end

  // Register access
  wire rd_status = reg_rd && reg_addr == `ACDS_ADDR_STATUS;
  wire rd_latch = reg_rd && reg_addr == `ACDS_ADDR_LATCHED;
  wire wr_status = reg_wr && reg_addr == `ACDS_ADDR_STATUS;
  wire wr_latch = reg_wr && reg_addr == `ACDS_ADDR_LATCHED;

  reg status_rsv;
  reg [3:0] latch_rsv;
  reg latched_master_halt;
  reg latched_clock_error;

  // Reserved bits keep what software writes
  always @(posedge ref_clk) begin
    if (rst) begin
      status_rsv <= 1'b0;
      latch_rsv <= 4'h0;
    end else begin
      if (wr_status)
        status_rsv <= reg_wdata[7];
      if (wr_latch)
        latch_rsv <= {reg_wdata[7:5], reg_wdata[3]};
    end
  end

  // Set wins over the read clear
  always @(posedge ref_clk) begin
    if (rst) begin
      latched_master_halt <= 1'b0;
      latched_clock_error <= 1'b0;
    end else begin
      latched_master_halt <= (latched_master_halt & ~rd_latch) |
        flags[`ACDS_B_MCLK_HALT];
      latched_clock_error <= (latched_clock_error & ~rd_latch) | err_now;
    end
  end

  // Read strobe answered one cycle later
  always @(posedge ref_clk) begin
    if (rst)
      reg_rdata_valid <= 1'b0;
    else
      reg_rdata_valid <= reg_rd;
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= `ACDS_LATCH_RST;
    end else begin
      if (rd_status)
        reg_rdata <= {status_rsv, flags};
      else if (rd_latch)
        reg_rdata <= {latch_rsv[3:1], latched_master_halt, latch_rsv[0],
          flags[`ACDS_B_SER_MISS], resync_in_progress, latched_clock_error};
      else if (reg_rd)
        reg_rdata <= 8'h00;
    end
  end

endmodule // acds_top

// ==== core/acds_defs.vh ====
`ifndef ACDS_DEFS_VH
`define ACDS_DEFS_VH
// Clock rate
`define ACDS_CLK_MHZ 20
// Register offsets
`define ACDS_ADDR_STATUS 8'h5e
`define ACDS_ADDR_LATCHED 8'h5f
// Live status bits
`define ACDS_B_MCLK_HALT 6
`define ACDS_B_PLL_UNLK 5
`define ACDS_B_SER_MISS 4
`define ACDS_B_COMBO 3
`define ACDS_B_MCLK_INV 2
`define ACDS_B_SCLK_INV 1
`define ACDS_B_FS_INV 0
// Latched status bits
`define ACDS_B_LT_HALT 4
`define ACDS_B_CK_MISS 2
`define ACDS_B_RESYNC 1
`define ACDS_B_CK_ERR 0
// Reset values
`define ACDS_FLAGS_RST 7'h7f
`define ACDS_LATCH_RST 8'h00
// Bit clock ratio window and low-phase limit
`define ACDS_SCLK_MIN 9'h020
`define ACDS_SCLK_MAX 9'h100
`define ACDS_LOW_LIMIT 4'h5
// Lowest master clock ratio refused for auto setup at high rates
`define ACDS_AUTO_MAX_RATIO 12'h200
// Times in ns and derived cycle counts
`define ACDS_MCLK_HALT_NS 5000
`define ACDS_MCLK_HALT_CYC ((`ACDS_MCLK_HALT_NS*`ACDS_CLK_MHZ+999)/1000)
`define ACDS_MISS_NS 100000
`define ACDS_MISS_CYC ((`ACDS_MISS_NS*`ACDS_CLK_MHZ+999)/1000)
`define ACDS_RESYNC_NS 10000
`define ACDS_RESYNC_CYC ((`ACDS_RESYNC_NS*`ACDS_CLK_MHZ+999)/1000)
// Frame period limits: 8 kHz slowest, 192 kHz fastest, 96 kHz boundary
`define ACDS_FRAME_MAX_NS 125000
`define ACDS_FRAME_MAX_CYC ((`ACDS_FRAME_MAX_NS*`ACDS_CLK_MHZ)/1000)
`define ACDS_FRAME_MIN_NS 5208
`define ACDS_FRAME_MIN_CYC ((`ACDS_FRAME_MIN_NS*`ACDS_CLK_MHZ+999)/1000)
`define ACDS_FAST_NS 10416
`define ACDS_FAST_CYC ((`ACDS_FAST_NS*`ACDS_CLK_MHZ)/1000)
`endif

// ==== bench/acds_src_model.sv ====
`timescale 1ns/1ps
module acds_src_model (
  input wire run,
  input wire mclk_on,
  input wire short_low,
  output logic mclk,
  output logic sclk,
  output logic lrclk
);
  // Master clock at 64 per frame, held low when halted
  initial begin
    mclk = 1'b0;
    forever #200 mclk = mclk_on ? ~mclk : 1'b0;
  end
  // 64 bit clocks per frame, low phase 32 or 4; both idle low while run is low
  initial begin
    sclk = 1'b0;
    lrclk = 1'b0;
    forever begin
      if (run) begin
        for (int i = 0; i < 64; i++) begin
          lrclk = (i >= (short_low ? 4 : 32));
          #200 sclk = 1'b1;
          #200 sclk = 1'b0;
        end
      end else begin
        lrclk = 1'b0;
        #400;
      end
    end
  end
endmodule // acds_src_model

// ==== bench/acds_top_monitor.sv ====
`timescale 1ns/1ps
module acds_top_monitor #(
  parameter MCLK_HALT_CYC = 100,
  parameter MISS_CYC = 2000
) (
  input wire ref_clk,
  input wire rst,
  input wire mclk,
  input wire sclk,
  input wire lrclk,
  input wire pll_enable,
  input wire ignore_all_errors,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rdata_valid
);
  int unsigned lo_cnt = 0;
  int unsigned hold_cnt = 0;
  logic mq = 1'b0;
  // Cycles with both serial pins low, cycles without a master clock change
  always @(posedge ref_clk) begin
    lo_cnt <= (sclk || lrclk) ? 0 : lo_cnt + 1;
    hold_cnt <= (mclk != mq) ? 0 : hold_cnt + 1;
    mq <= mclk;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence rd_live;
    reg_rd && reg_addr == 8'h5e;
  endsequence
  sequence rd_latch;
    reg_rd && reg_addr == 8'h5f;
  endsequence
  a_valid_after_rd: assert property (reg_rd |=> reg_rdata_valid)
    else $error("read not answered");
  a_no_spurious_valid: assert property (reg_rdata_valid |-> $past(reg_rd))
    else $error("valid without read");
  a_pll_off_flag: assert property (rd_live ##0 (!pll_enable && !$past(pll_enable, 3))
    |=> reg_rdata[5]) else $error("pll flag clear");
  a_ignore_mask: assert property (rd_live ##0 (ignore_all_errors && $past(ignore_all_errors, 3))
    |=> !reg_rdata[0]) else $error("rate flag not masked");
  a_err_latched: assert property (rd_latch ##0 (!pll_enable && !$past(pll_enable, 3))
    |=> reg_rdata[0]) else $error("error not latched");
  a_miss_live: assert property (rd_live ##0 (lo_cnt > MISS_CYC + 8) |=> reg_rdata[4])
    else $error("missing flag clear");
  a_miss_copy: assert property (rd_latch ##0 (lo_cnt > MISS_CYC + 8) |=> reg_rdata[2])
    else $error("missing copy clear");
  a_halt_live: assert property (rd_live ##0 (hold_cnt > MCLK_HALT_CYC + 8) |=> reg_rdata[6])
    else $error("halt flag clear");
  a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h5e && reg_addr != 8'h5f
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // acds_top_monitor
bind acds_top acds_top_monitor #(.MCLK_HALT_CYC(MCLK_HALT_CYC), .MISS_CYC(MISS_CYC)) u_mon (
  .ref_clk(ref_clk), .rst(rst), .mclk(mclk), .sclk(sclk), .lrclk(lrclk),
  .pll_enable(pll_enable), .ignore_all_errors(ignore_all_errors), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid));

// ==== bench/test_audio_clock_detector_status.sv ====
`timescale 1ns/1ps
module test_audio_clock_detector_status;
  logic ref_clk = 0, rst = 1, pll_enable = 0, pll_locked = 0, ignore_all_errors = 0;
  logic reg_wr = 0, reg_rd = 0, run = 0, mclk_on = 0, short_low = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire mclk, sclk, lrclk, reg_rdata_valid;
  wire [7:0] reg_rdata;
  int n_mismatch = 0, comparisons = 0;
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  acds_src_model src (.run(run), .mclk_on(mclk_on), .short_low(short_low), .mclk(mclk),
    .sclk(sclk), .lrclk(lrclk));
  acds_top #(.MCLK_HALT_CYC(20), .MISS_CYC(50), .RESYNC_CYC(10)) uut (
    .ref_clk(ref_clk), .rst(rst), .mclk(mclk), .sclk(sclk), .lrclk(lrclk),
    .pll_enable(pll_enable), .pll_locked(pll_locked), .ignore_all_errors(ignore_all_errors),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid));
  task chk(input logic [7:0] got, input logic [7:0] m, input logic [7:0] e);
    comparisons++;
    if ((got & m) !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h mask %h exp %h", $time, got, m, e);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk({7'h00, reg_rdata_valid}, 8'h01, 8'h01);
    chk(reg_rdata, m, e);
    @(posedge ref_clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task t_running;
    run <= 1'b1;
    mclk_on <= 1'b1;
    pll_enable <= 1'b1;
    pll_locked <= 1'b1;
    repeat (1600) @(posedge ref_clk);
    rd(8'h5e, 8'hff, 8'h00);
    rd(8'h5f, 8'h01, 8'h01);
    rd(8'h5f, 8'h17, 8'h00);
  endtask
  task t_short;
    short_low <= 1'b1;
    repeat (1700) @(posedge ref_clk);
    rd(8'h5e, 8'h0f, 8'h0c);
    short_low <= 1'b0;
    repeat (1700) @(posedge ref_clk);
    rd(8'h5e, 8'h0f, 8'h00);
  endtask
  task t_pll;
    pll_enable <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(8'h5e, 8'h20, 8'h20);
    rd(8'h5f, 8'h01, 8'h01);
    pll_enable <= 1'b1;
    pll_locked <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(8'h5e, 8'h20, 8'h20);
    pll_locked <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(8'h5f, 8'h02, 8'h02);
    rd(8'h5e, 8'h20, 8'h00);
  endtask
  task t_write;
    wr(8'h5e, 8'hff);
    rd(8'h5e, 8'hff, 8'h80);
    wr(8'h5e, 8'h00);
    wr(8'h5f, 8'hff);
    rd(8'h5f, 8'he8, 8'he8);
    wr(8'h5f, 8'h00);
    rd(8'h40, 8'hff, 8'h00);
  endtask
  task t_halt;
    mclk_on <= 1'b0;
    repeat (40) @(posedge ref_clk);
    rd(8'h5e, 8'h44, 8'h44);
    mclk_on <= 1'b1;
    repeat (1700) @(posedge ref_clk);
    rd(8'h5f, 8'h11, 8'h11);
    rd(8'h5f, 8'h11, 8'h00);
    rd(8'h5e, 8'hff, 8'h00);
  endtask
  task t_missing;
    run <= 1'b0;
    repeat (3200) @(posedge ref_clk);
    rd(8'h5e, 8'h7f, 8'h1f);
    rd(8'h5f, 8'h05, 8'h05);
    ignore_all_errors <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(8'h5e, 8'h01, 8'h00);
    ignore_all_errors <= 1'b0;
    run <= 1'b1;
    repeat (1700) @(posedge ref_clk);
    rd(8'h5e, 8'h11, 8'h00);
  endtask
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_running;
    t_short;
    t_pll;
    t_write;
    t_halt;
    t_missing;
    tally_and_finish;
  end
endmodule // test_audio_clock_detector_status
